// ---- rtl/ffmd_detector.sv ----
// Overview of operation
// - combine_or_select picks freefall (AND) or motion (OR) detection.
// - all three axis enables clear means detector disabled, no event.
// - latch-enable and combine-select give four operating modes.
// - non-latched freefall sets event_active_flag only after debounce ends.
// - clear-mode 0: flag clears only after counter decrements back down.
// - clear-mode 1: flag clears at once, re-set needs full debounce again.
// - axis event/polarity flags show live undebounced status when enabled.
// - latched freefall: flag sets at count, holds until source read.
// - latched: source read clears flag and counter; then full debounce.
// - latched: axis flags freeze when flag sets, resume after source read.
// - non-latched motion behaves like freefall with both clear modes.
// - non-latched: source read has no side effect.
// - clear-mode 0 decrements counter, 1 clears it; default is 1.
// - freefall if all enabled magnitudes <= 7-bit threshold; motion if any >.
// - polarity 0 positive, 1 negative; reads zero when axis disabled.
// - latched motion holds flag until source read, which clears all bits.
`timescale 1ns/1ps
`default_nettype none
module ffmd_detector
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire ffmd_pkg::ffmd_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // sample stream from the conversion chain
  input wire ffmd_pkg::ffmd_sample_t sample,
  // event outputs
  output logic event_active_flag,
  output logic irq
);
  import ffmd_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] cfg;
    logic [6:0] ths;
    logic clr_mode;
    logic [FFMD_DBNC_W-1:0] length;
    logic [FFMD_DBNC_W-1:0] count;
    logic active;
    ffmd_axis_flags_t flags;
    logic [7:0] rdata;
    logic irq_stat;
    logic irq_mask;
  } ffmd_state_t;

  ffmd_state_t st_r;
  ffmd_state_t st_nxt;

  logic [2:0] axis_on;
  logic [2:0] axis_hi;
  logic [2:0] axis_neg;
  logic cond;
  logic latch_on;
  logic src_read;
  logic set_evt;
  ffmd_axis_flags_t live;
  logic [5:0] flag_keep;
  logic [FFMD_SAMPLE_W-1:0] mag_x;
  logic [FFMD_SAMPLE_W-1:0] mag_y;
  logic [FFMD_SAMPLE_W-1:0] mag_z;

  // ****************************************************************
  // magnitude helper
  // ****************************************************************
  function automatic logic [FFMD_SAMPLE_W-1:0] mag(
    input logic signed [FFMD_SAMPLE_W-1:0] v);
    logic [FFMD_SAMPLE_W-1:0] a;
    a = v[FFMD_SAMPLE_W-1] ? FFMD_SAMPLE_W'(-v) : FFMD_SAMPLE_W'(v);
    return a;
  endfunction

  // ****************************************************************
  // per-axis compare and combination
  // ****************************************************************
  always_comb
  begin
    axis_on = {st_r.cfg[FFMD_CFG_Z_BIT], st_r.cfg[FFMD_CFG_Y_BIT],
               st_r.cfg[FFMD_CFG_X_BIT]};
    // threshold compares against the top bits of the magnitude
    mag_x = mag(sample.x);
    mag_y = mag(sample.y);
    mag_z = mag(sample.z);
    axis_hi[0] = mag_x[FFMD_SAMPLE_W-1 -: 7] > st_r.ths;
    axis_hi[1] = mag_y[FFMD_SAMPLE_W-1 -: 7] > st_r.ths;
    axis_hi[2] = mag_z[FFMD_SAMPLE_W-1 -: 7] > st_r.ths;
    axis_neg = {sample.z[FFMD_SAMPLE_W-1], sample.y[FFMD_SAMPLE_W-1],
                sample.x[FFMD_SAMPLE_W-1]};
    if (axis_on == 3'b000)
      cond = 1'b0;
    else if (st_r.cfg[FFMD_CFG_OR_BIT])
      cond = |(axis_hi & axis_on);
    else
      cond = ~|(axis_hi & axis_on);
    // live flags, zero for disabled axes
    live.x_axis_event_flag = axis_on[0] & axis_hi[0];
    live.x_axis_polarity_flag = axis_on[0] & axis_neg[0];
    live.y_axis_event_flag = axis_on[1] & axis_hi[1];
    live.y_axis_polarity_flag = axis_on[1] & axis_neg[1];
    live.z_axis_event_flag = axis_on[2] & axis_hi[2];
    live.z_axis_polarity_flag = axis_on[2] & axis_neg[2];
    flag_keep = {axis_on[2], axis_on[2], axis_on[1], axis_on[1],
                 axis_on[0], axis_on[0]};
  end

  assign latch_on = st_r.cfg[FFMD_CFG_LATCH_BIT];
  assign src_read = bus_req.rd && bus_req.addr == FFMD_SRC_ADDR;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    set_evt = 1'b0;
    // debounce, stepped once per sample
    if (sample.valid)
    begin
      if (cond)
      begin
        // saturate at the target: clear-mode 0 then drops the flag
        // exactly length samples after the condition ends
        if (st_r.count < st_r.length)
          st_nxt.count = st_r.count + 1'b1;
      end
      else if (st_r.clr_mode)
        st_nxt.count = '0;
      else if (st_r.count != '0)
        st_nxt.count = st_r.count - 1'b1;
      if (latch_on)
      begin
        // latched: set at target, hold until source read
        if (cond && st_nxt.count >= st_r.length && !st_r.active)
        begin
          st_nxt.active = 1'b1;
          set_evt = 1'b1;
        end
      end
      else if (cond && st_nxt.count >= st_r.length)
      begin
        st_nxt.active = 1'b1;
        set_evt = !st_r.active;
      end
      else if (!cond && st_r.clr_mode)
        st_nxt.active = 1'b0;
      else if (!cond && st_nxt.count == '0)
        st_nxt.active = 1'b0;
      // axis flags live unless frozen by a latched event
      if (!(latch_on && st_nxt.active))
        st_nxt.flags = live;
      else if (!st_r.active)
        st_nxt.flags = live;
      // a frozen set must not show an axis switched off meanwhile
      st_nxt.flags = ffmd_axis_flags_t'(st_nxt.flags & flag_keep);
    end
    if (axis_on == 3'b000)
    begin
      st_nxt.active = 1'b0;
      st_nxt.count = '0;
      st_nxt.flags = '0;
    end
    // source read: latched clears, non-latched no effect
    // a read on the setting sample loses, so no event is missed
    if (src_read && latch_on && !set_evt)
    begin
      st_nxt.active = 1'b0;
      st_nxt.count = '0;
      st_nxt.flags = '0;
    end
    // register writes
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        FFMD_CFG_ADDR: st_nxt.cfg = {bus_req.wdata[7:3], 3'h0};
        FFMD_THS_ADDR:
        begin
          st_nxt.clr_mode = bus_req.wdata[FFMD_THS_CLRMODE_BIT];
          st_nxt.ths = bus_req.wdata[6:0];
        end
        FFMD_CNT_ADDR: st_nxt.length = bus_req.wdata;
        FFMD_IRQ_MASK_ADDR: st_nxt.irq_mask = bus_req.wdata[0];
        default: ;
      endcase
    end
    // sticky interrupt status, set wins over clear
    if (bus_req.wr && bus_req.addr == FFMD_IRQ_STAT_ADDR && bus_req.wdata[0])
      st_nxt.irq_stat = 1'b0;
    if (set_evt)
      st_nxt.irq_stat = 1'b1;
    // read data, one cycle later
    st_nxt.rdata = 8'h00;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        FFMD_CFG_ADDR: st_nxt.rdata = st_r.cfg;
        FFMD_SRC_ADDR: st_nxt.rdata = {st_r.active, 1'b0, st_r.flags};
        FFMD_THS_ADDR: st_nxt.rdata = {st_r.clr_mode, st_r.ths};
        FFMD_CNT_ADDR: st_nxt.rdata = st_r.length;
        FFMD_IRQ_STAT_ADDR: st_nxt.rdata = {7'h00, st_r.irq_stat};
        FFMD_IRQ_MASK_ADDR: st_nxt.rdata = {7'h00, st_r.irq_mask};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.cfg <= FFMD_CFG_RST;
      st_r.ths <= FFMD_THS_RST;
      st_r.clr_mode <= FFMD_CLRMODE_RST;
      st_r.length <= FFMD_CNT_RST;
      st_r.count <= '0;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign event_active_flag = st_r.active;
  assign irq = st_r.irq_stat & st_r.irq_mask;
  assign bus_rdata = st_r.rdata;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_disabled_no_event: assert property (
    (st_r.cfg[5:3] == 3'b000) |=> !event_active_flag)
    else $error("event active while all axes disabled");
  a_latched_holds: assert property (
    (latch_on && event_active_flag && !src_read && st_r.cfg[5:3] != 3'b000
     && !(bus_req.wr && bus_req.addr == FFMD_CFG_ADDR))
    |=> event_active_flag)
    else $error("latched event dropped without source read");
  a_read_clears_latch: assert property (
    (src_read && latch_on && event_active_flag) |=> !event_active_flag
      && st_r.count == '0)
    else $error("source read did not clear latched event");
  a_nonlatched_read_quiet: assert property (
    (src_read && !latch_on && event_active_flag && !sample.valid
     && !bus_req.wr) |=> event_active_flag)
    else $error("source read changed non-latched event");
  a_set_needs_count: assert property (
    $rose(event_active_flag) |-> st_r.count >= st_r.length)
    else $error("event set before debounce complete");
  a_fast_clear: assert property (
    (sample.valid && !cond && st_r.clr_mode && !latch_on)
    |=> !event_active_flag && st_r.count == '0)
    else $error("clear mode 1 did not clear at once");
  a_flags_frozen: assert property (
    (latch_on && event_active_flag && !src_read && $stable(st_r.cfg))
    |=> $stable(st_r.flags))
    else $error("axis flags changed while latched");
  a_disabled_axis_zero: assert property (
    (sample.valid && !st_r.cfg[FFMD_CFG_X_BIT] && !src_read)
    |=> !st_r.flags.x_axis_polarity_flag)
    else $error("disabled axis shows polarity");
  a_irq_level: assert property (
    irq == (st_r.irq_stat && st_r.irq_mask))
    else $error("interrupt not matching masked status");

  a_count_steps: assert property (
    (sample.valid && cond && st_r.count < st_r.length
     && !src_read)
    |=> st_r.count == $past(st_r.count) + 8'h01)
    else $error("debounce count did not step");

  a_decrement_holds: assert property (
    (sample.valid && !cond && !st_r.clr_mode && !latch_on
     && axis_on != 3'b000 && st_r.count > 8'h01)
    |=> $stable(event_active_flag))
    else $error("clear mode 0 dropped flag early");

  a_decrement_drops: assert property (
    (sample.valid && !cond && !st_r.clr_mode && !latch_on
     && st_r.count <= 8'h01)
    |=> !event_active_flag)
    else $error("clear mode 0 kept flag at zero count");

  a_motion_any: assert property (
    (sample.valid && st_r.cfg[FFMD_CFG_OR_BIT] && |(axis_hi & axis_on)
     && st_r.length == '0 && !src_read)
    |=> event_active_flag)
    else $error("motion on one axis raised no event");

  a_freefall_all: assert property (
    (sample.valid && !st_r.cfg[FFMD_CFG_OR_BIT] && axis_on != 3'b000
     && (axis_hi & axis_on) == 3'b000 && st_r.length == '0 && !src_read)
    |=> event_active_flag)
    else $error("freefall on all axes raised no event");

  a_flags_live: assert property (
    (sample.valid && !latch_on)
    |=>
    st_r.flags == $past(live))
    else $error("axis flags not live in non-latched mode");

  a_irq_sticky: assert property (
    (st_r.irq_stat && !(bus_req.wr && bus_req.addr == FFMD_IRQ_STAT_ADDR
     && bus_req.wdata[0]))
    |=> st_r.irq_stat)
    else $error("interrupt status dropped without clear");

  a_src_read_active: assert property (
    (bus_req.rd && bus_req.addr == FFMD_SRC_ADDR)
    |=>
    bus_rdata[FFMD_SRC_ACTIVE_BIT] == $past(event_active_flag))
    else $error("source read shows wrong active flag");

  a_rdata_idle: assert property (
    (!bus_req.rd)
    |=>
    bus_rdata == 8'h00)
    else $error("read data not zero outside read answer");

  // ****************************************************************
  // coverage
  // ****************************************************************
  c_event_set: cover property ($rose(event_active_flag));
  c_freefall_set: cover property (!st_r.cfg[FFMD_CFG_OR_BIT]
    && $rose(event_active_flag));
  c_latched_clear: cover property (src_read && latch_on && event_active_flag);
  c_decrement: cover property (sample.valid && !cond && !st_r.clr_mode
    && st_r.count > 1);
  c_motion_mode: cover property (st_r.cfg[FFMD_CFG_OR_BIT]
    && $rose(event_active_flag));

endmodule // ffmd_detector
`default_nettype wire

// ---- rtl/ffmd_pkg.sv ----
package ffmd_pkg;

  // ****************************************************************
  // register offsets (sensor address space)
  // ****************************************************************
  localparam logic [7:0] FFMD_CFG_ADDR = 8'h15;
  localparam logic [7:0] FFMD_SRC_ADDR = 8'h16;
  localparam logic [7:0] FFMD_THS_ADDR = 8'h17;
  localparam logic [7:0] FFMD_CNT_ADDR = 8'h18;
  localparam logic [7:0] FFMD_IRQ_STAT_ADDR = 8'h40;
  localparam logic [7:0] FFMD_IRQ_MASK_ADDR = 8'h41;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FFMD_CFG_LATCH_BIT = 7;
  localparam int FFMD_CFG_OR_BIT = 6;
  localparam int FFMD_CFG_Z_BIT = 5;
  localparam int FFMD_CFG_Y_BIT = 4;
  localparam int FFMD_CFG_X_BIT = 3;
  localparam int FFMD_THS_CLRMODE_BIT = 7;
  localparam int FFMD_SRC_ACTIVE_BIT = 7;

  // ****************************************************************
  // reset values and widths
  // ****************************************************************
  localparam logic [7:0] FFMD_CFG_RST = 8'h00;
  localparam logic [6:0] FFMD_THS_RST = 7'h00;
  localparam logic FFMD_CLRMODE_RST = 1'b1;
  localparam logic [7:0] FFMD_CNT_RST = 8'h00;
  localparam int FFMD_SAMPLE_W = 14;
  localparam int FFMD_DBNC_W = 8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ffmd_bus_req_t;

  typedef struct packed {
    logic valid;
    logic signed [FFMD_SAMPLE_W-1:0] x;
    logic signed [FFMD_SAMPLE_W-1:0] y;
    logic signed [FFMD_SAMPLE_W-1:0] z;
  } ffmd_sample_t;

  typedef struct packed {
    logic z_axis_event_flag;
    logic z_axis_polarity_flag;
    logic y_axis_event_flag;
    logic y_axis_polarity_flag;
    logic x_axis_event_flag;
    logic x_axis_polarity_flag;
  } ffmd_axis_flags_t;

endpackage

// ---- verification/test_ffmd_detector.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_ffmd_detector;
  import ffmd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ffmd_bus_req_t bus_req = '0;
  ffmd_sample_t sample = '0;
  logic [7:0] bus_rdata;
  logic event_active_flag;
  logic irq;
  int num_errors = 0;
  int checks_done = 0;
  // reference state after the last request taken
  logic [7:0] cfg, len, fl, fm, cnt, e_rd, rm;
  logic [6:0] ths;
  logic cm, act, stat, msk, fresh, rdv;
  logic signed [13:0] nx, ny, nz;
  logic [7:0] ad [7] = '{8'h15, 8'h17, 8'h18, 8'h16, 8'h40, 8'h41, 8'h33};

  ffmd_detector ffmd_detector_inst (
    .clk(clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .sample(sample),
    .event_active_flag(event_active_flag),
    .irq(irq)
  );

  always #5 clk = ~clk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic hi(input logic signed [13:0] v);
    logic [13:0] m;
    m = v[13] ? -v : v;
    return m[13:7] > ths;
  endfunction

  // values straddle the threshold so both conditions occur often
  function automatic logic [13:0] axis();
    int t;
    t = int'(ths) + $urandom_range(3) - 2;
    if (t < 0) t = 0;
    if (t > 63) t = 63;
    t = t * 128 + $urandom_range(127);
    return $urandom_range(1) ? 14'(-t) : 14'(t);
  endfunction

  function automatic void mreset();
    {cfg, len, cnt, fl, ths, act, stat, msk, fresh, rdv} = '0;
    cm = 1'b1;
    fm = 8'hFF;
  endfunction

  // ****************************************************************
  // one request: 0 idle, 1 write, 2 read, 3 sample, 4 reset
  // ****************************************************************
  task automatic tick(input int k, input logic [7:0] a, input logic [7:0] d);
    logic c, o;
    logic [2:0] h, en;
    @(posedge clk);
    rst_n <= (k != 4);
    bus_req <= '{addr: a, wdata: d, wr: k == 1, rd: k == 2};
    sample <= '{valid: k == 3, x: nx, y: ny, z: nz};
    @(negedge clk);
    cmp({7'h00, event_active_flag}, {7'h00, act});
    cmp({7'h00, irq}, {7'h00, stat & msk});
    cmp(bus_rdata & rm, (rdv ? e_rd : 8'h00) & rm);
    o = act;
    fresh = 1'b0;
    rdv = (k == 2);
    rm = 8'hFF;
    if (k == 4)
      mreset();
    if (k == 1)
      case (a)
        FFMD_CFG_ADDR: cfg = {d[7:3], 3'b000};
        FFMD_THS_ADDR: {cm, ths} = d;
        FFMD_CNT_ADDR: len = d;
        FFMD_IRQ_STAT_ADDR: stat = stat & ~d[0];
        FFMD_IRQ_MASK_ADDR: msk = d[0];
        default: ;
      endcase
    if (k == 2)
    begin
      case (a)
        FFMD_CFG_ADDR: e_rd = cfg;
        FFMD_THS_ADDR: e_rd = {cm, ths};
        FFMD_CNT_ADDR: e_rd = len;
        FFMD_SRC_ADDR: e_rd = {act, 1'b0, fl[5:0]};
        FFMD_IRQ_STAT_ADDR: e_rd = {7'h00, stat};
        FFMD_IRQ_MASK_ADDR: e_rd = {7'h00, msk};
        default: e_rd = 8'h00;
      endcase
      if (a == FFMD_SRC_ADDR)
        rm = fm;
      if (a == FFMD_SRC_ADDR && cfg[7])
      begin
        {act, cnt, fl} = '0;
        fm = 8'hFF;
      end
    end
    if (k == 3)
    begin
      en = cfg[5:3];
      h = {hi(nz), hi(ny), hi(nx)} & en;
      c = (en != 3'b000) && (cfg[6] ? h != 3'b000 : h == 3'b000);
      if (!(cfg[7] && act))
      begin
        fl = {2'b00, h[2], nz[13] & h[2], h[1], ny[13] & h[1],
              h[0], nx[13] & h[0]};
        fm = ~{3'b000, en[2] & ~h[2], 1'b0, en[1] & ~h[1], 1'b0, en[0] & ~h[0]};
      end
      if (c)
      begin
        if (cnt < len) cnt = cnt + 8'h01;
        if (cnt >= len) act = 1'b1;
      end
      else if (cm)
      begin
        cnt = 8'h00;
        if (!cfg[7]) act = 1'b0;
      end
      else
      begin
        if (cnt != 8'h00) cnt = cnt - 8'h01;
        if (cnt == 8'h00 && !cfg[7]) act = 1'b0;
      end
      fresh = act & ~o;
      stat = stat | fresh;
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    int r;
    mreset();
    rm = 8'hFF;
    {nx, ny, nz} = '0;
    void'($urandom(32'h77d3));
    repeat (6) @(posedge clk);
    for (int n = 0; n < 40; n++)
    begin
      tick(4, 8'h00, 8'h00);
      tick(2, FFMD_THS_ADDR, 8'h00);
      // first eight walk all modes with both clear modes
      tick(1, FFMD_CFG_ADDR, n < 8 ? {n[1:0], 6'h3F}
        : (n == 8 ? 8'hC7 : 8'($urandom)));
      tick(1, FFMD_THS_ADDR, {n < 8 ? n[2] : 1'($urandom),
        7'($urandom_range(63))});
      tick(1, FFMD_CNT_ADDR, 8'($urandom_range(4)));
      tick(1, FFMD_IRQ_MASK_ADDR, 8'($urandom));
      tick(2, FFMD_CFG_ADDR, 8'h00);
      repeat (40)
      begin
        r = fresh ? 9 : $urandom_range(9);
        nx = axis();
        ny = axis();
        nz = axis();
        if (r < 5) tick(3, 8'h00, 8'h00);
        else if (r < 7) tick(2, FFMD_SRC_ADDR, 8'h00);
        else if (r == 7) tick(2, ad[$urandom_range(6)], 8'h00);
        else if (r == 8) tick(1, ad[$urandom_range(6, 3)], 8'($urandom));
        else tick(0, 8'h00, 8'h00);
      end
    end
    close_out();
  end

  initial
  begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule // test_ffmd_detector
`default_nettype wire
